// [hdl/tec_calc.v]
`timescale 1ns/1ps
`include "tec_defs.vh"
// How it works
// - Heat or cooling register, not both, plus both sums update on each integration
// - Heat uses inlet minus outlet difference
// - Cooling uses outlet minus inlet difference
// - Coefficient taken at inlet or outlet temperature
// - Heat if inlet hotter, cooling if colder
// - Switch limit gates heat and cooling
// - Volume times temperature added to sums
// - Sums step once per volume count
// - Sum readout scaled by volume resolution
// - Energy kept internally in raw counts, 100000000000 per Wh
// - Readout divided to Wh, kWh, MWh or GJ
// - Errors freeze the registers they affect
// - Affected readings flagged invalid
// - Signed offset clamped to plus/minus 0.99 K
// - Zero offset leaves temperatures unchanged
// - Offset function can be disabled entirely
// - Real or simulated volume counts used alike
module tec_calc #(
	parameter NW = 96,
	parameter [31:0] K_BASE = 32'h0011_b340,
	parameter [31:0] K_SLOPE = 32'h0000_0001
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [15:0] inlet_temperature,
	input wire [15:0] outlet_temperature,
	input wire inlet_error,
	input wire outlet_error,
	input wire flow_error,
	input wire vol_strobe,
	input wire sim_vol_strobe,
	output reg inlet_invalid,
	output reg outlet_invalid,
	output reg diff_invalid,
	output reg flow_invalid,
	output reg power_invalid,
	output reg energy_invalid,
	output reg inlet_sum_invalid,
	output reg outlet_sum_invalid
);
	localparam [1:0] JOB_HEAT = 2'h0;
	localparam [1:0] JOB_COOL = 2'h1;
	localparam [1:0] JOB_INSUM = 2'h2;
	localparam [1:0] JOB_OUTSUM = 2'h3;

	// Negative temperatures count as zero in products
	function [15:0] tec_pos;
		input [16:0] t;
		begin
			if (t[16])
				tec_pos = 16'h0000;
			else
				tec_pos = t[15:0];
		end
	endfunction

	// Divisor for each conversion job
	function [63:0] tec_div_sel;
		input [1:0] job;
		input [1:0] unit;
		input [1:0] res;
		begin
			if (job == JOB_HEAT || job == JOB_COOL) begin
				case (unit)
					`TEC_UNIT_KWH: tec_div_sel = `TEC_RAW_PER_WH * `TEC_WH_PER_KWH;
					`TEC_UNIT_MWH: tec_div_sel = `TEC_RAW_PER_WH * `TEC_WH_PER_MWH;
					`TEC_UNIT_GJ: tec_div_sel = `TEC_RAW_PER_WH * `TEC_WH_PER_GJ;
					default: tec_div_sel = `TEC_RAW_PER_WH;
				endcase
			end else begin
				case (res)
					2'h0: tec_div_sel = `TEC_SUM_DIV_R0;
					2'h1: tec_div_sel = `TEC_SUM_DIV_R1;
					2'h2: tec_div_sel = `TEC_SUM_DIV_R2;
					default: tec_div_sel = `TEC_SUM_DIV_R3;
				endcase
			end
		end
	endfunction

	reg [31:0] ctrl_r;
	reg [7:0] offset_r;
	reg [15:0] limit_r;
	reg [31:0] rd_nxt;
	reg hit_nxt;

	wire at_outlet = ctrl_r[`TEC_CTRL_AT_OUTLET];
	wire limit_en = ctrl_r[`TEC_CTRL_LIMIT_EN];
	wire offset_en = ctrl_r[`TEC_CTRL_OFFSET_EN];
	wire sim_vol = ctrl_r[`TEC_CTRL_SIM_VOL];
	wire [1:0] unit_sel = ctrl_r[`TEC_CTRL_UNIT_LSB+1:`TEC_CTRL_UNIT_LSB];
	wire [1:0] res_code = ctrl_r[`TEC_CTRL_RES_LSB+1:`TEC_CTRL_RES_LSB];

	// Integration event and corrected temperatures
	wire vol_event = sim_vol ? sim_vol_strobe : vol_strobe;
	wire [16:0] offset_eff = offset_en ? {{9{offset_r[7]}}, offset_r} : 17'h0_0000;
	wire [16:0] t1_corr = {inlet_temperature[15], inlet_temperature} + offset_eff;
	wire [16:0] t2_corr = {outlet_temperature[15], outlet_temperature} + offset_eff;
	reg [9:0] litres;

	always @* begin
		case (res_code)
			2'h0: litres = `TEC_LITRES_R0;
			2'h1: litres = `TEC_LITRES_R1;
			2'h2: litres = `TEC_LITRES_R2;
			default: litres = `TEC_LITRES_R3;
		endcase
	end

	reg ev_r;
	reg [16:0] t1_r;
	reg [16:0] t2_r;
	reg [9:0] vl_r;
	reg in_err_r;
	reg out_err_r;
	reg flow_err_r;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_r <= 1'h0;
			t1_r <= 17'h0_0000;
			t2_r <= 17'h0_0000;
			vl_r <= 10'h000;
			in_err_r <= 1'h0;
			out_err_r <= 1'h0;
			flow_err_r <= 1'h0;
		end else begin
			ev_r <= vol_event;
			if (vol_event) begin
				t1_r <= t1_corr;
				t2_r <= t2_corr;
				vl_r <= litres;
				in_err_r <= inlet_error;
				out_err_r <= outlet_error;
				flow_err_r <= flow_error;
			end
		end
	end

	// Increments for the captured event
	wire [17:0] diff = {t1_r[16], t1_r} - {t2_r[16], t2_r};
	wire diff_neg = diff[17];
	wire diff_zero = (diff == 18'h0_0000);
	wire [17:0] dmag = diff_neg ? (18'h0_0000 - diff) : diff;
	wire [15:0] k_temp = at_outlet ? tec_pos(t2_r) : tec_pos(t1_r);
	wire [31:0] k_prod = K_SLOPE * {16'h0000, k_temp};
	wire [31:0] k_coef = K_BASE - k_prod;
	wire [NW-1:0] e_inc = {{(NW-10){1'h0}}, vl_r} * {{(NW-18){1'h0}}, dmag} * {{(NW-32){1'h0}}, k_coef}
		* {{(NW-10){1'h0}}, `TEC_KWH_TO_WH};
	wire t1_ge_lim = $signed(t1_r) >= $signed({1'h0, limit_r});
	wire any_err = in_err_r | out_err_r | flow_err_r;
	wire heat_add = ev_r & ~any_err & ~diff_neg & ~diff_zero & (~limit_en | t1_ge_lim);
	wire cool_add = ev_r & ~any_err & diff_neg & (~limit_en | ~t1_ge_lim);
	wire in_add = ev_r & ~in_err_r & ~flow_err_r;
	wire out_add = ev_r & ~out_err_r & ~flow_err_r;
	wire [63:0] in_inc = {54'h0, vl_r} * {48'h0, tec_pos(t1_r)};
	wire [63:0] out_inc = {54'h0, vl_r} * {48'h0, tec_pos(t2_r)};

	reg [NW-1:0] heat_acc_r;
	reg [NW-1:0] cool_acc_r;
	reg [63:0] insum_acc_r;
	reg [63:0] outsum_acc_r;
	reg [31:0] volume_r;

	// Both sums and at most one of heat or cooling advance together on one event
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			heat_acc_r <= {NW{1'h0}};
			cool_acc_r <= {NW{1'h0}};
			insum_acc_r <= 64'h0000_0000_0000_0000;
			outsum_acc_r <= 64'h0000_0000_0000_0000;
			volume_r <= 32'h0000_0000;
		end else begin
			if (heat_add)
				heat_acc_r <= heat_acc_r + e_inc;
			if (cool_add)
				cool_acc_r <= cool_acc_r + e_inc;
			if (in_add)
				insum_acc_r <= insum_acc_r + in_inc;
			if (out_add)
				outsum_acc_r <= outsum_acc_r + out_inc;
			if (ev_r && !flow_err_r)
				volume_r <= volume_r + 32'h0000_0001;
		end
	end

	// Invalid-reading flags follow the live error inputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			inlet_invalid <= 1'h0;
			outlet_invalid <= 1'h0;
			diff_invalid <= 1'h0;
			flow_invalid <= 1'h0;
			power_invalid <= 1'h0;
			energy_invalid <= 1'h0;
			inlet_sum_invalid <= 1'h0;
			outlet_sum_invalid <= 1'h0;
		end else begin
			inlet_invalid <= inlet_error;
			outlet_invalid <= outlet_error;
			diff_invalid <= inlet_error | outlet_error;
			flow_invalid <= flow_error;
			power_invalid <= inlet_error | outlet_error | flow_error;
			energy_invalid <= inlet_error | outlet_error | flow_error;
			inlet_sum_invalid <= inlet_error | flow_error;
			outlet_sum_invalid <= outlet_error | flow_error;
		end
	end

	// Background conversion to readout units, four jobs in turn
	reg [1:0] job_r;
	reg div_start_r;
	reg [63:0] heat_out_r;
	reg [63:0] cool_out_r;
	reg [63:0] insum_out_r;
	reg [63:0] outsum_out_r;
	reg [NW-1:0] div_a;
	wire [NW-1:0] div_q;
	wire div_done;
	wire [63:0] div_b = tec_div_sel(job_r, unit_sel, res_code);

	always @* begin
		case (job_r)
			JOB_HEAT: div_a = heat_acc_r;
			JOB_COOL: div_a = cool_acc_r;
			JOB_INSUM: div_a = {{(NW-64){1'h0}}, insum_acc_r};
			default: div_a = {{(NW-64){1'h0}}, outsum_acc_r};
		endcase
	end

	tec_div #(.NW(NW), .DW(64), .CW(7)) u_div (
		.clk(pclk),
		.rst_n(presetn),
		.start(div_start_r),
		.dividend(div_a),
		.divisor(div_b),
		.quotient(div_q),
		.done(div_done)
	);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			job_r <= JOB_HEAT;
			div_start_r <= 1'h1;
			heat_out_r <= 64'h0000_0000_0000_0000;
			cool_out_r <= 64'h0000_0000_0000_0000;
			insum_out_r <= 64'h0000_0000_0000_0000;
			outsum_out_r <= 64'h0000_0000_0000_0000;
		end else begin
			div_start_r <= div_done;
			if (div_done) begin
				job_r <= job_r + 2'h1;
				case (job_r)
					JOB_HEAT: heat_out_r <= div_q[63:0];
					JOB_COOL: cool_out_r <= div_q[63:0];
					JOB_INSUM: insum_out_r <= div_q[63:0];
					default: outsum_out_r <= div_q[63:0];
				endcase
			end
		end
	end

	// APB slave, answers in the first access cycle
	wire [31:0] status = {25'h000_0000, ~offset_en, outlet_sum_invalid, inlet_sum_invalid,
		energy_invalid, flow_invalid, outlet_invalid, inlet_invalid};
	wire wr_en = psel & penable & pready & pwrite;
	wire [7:0] wr_off = pwdata[7:0];

	always @* begin
		hit_nxt = 1'h1;
		case (paddr)
			`TEC_ADDR_CTRL: rd_nxt = ctrl_r;
			`TEC_ADDR_OFFSET: rd_nxt = offset_en ? {{24{offset_r[7]}}, offset_r} : 32'h0000_0000;
			`TEC_ADDR_LIMIT: rd_nxt = {16'h0000, limit_r};
			`TEC_ADDR_STATUS: rd_nxt = status;
			`TEC_ADDR_VOLUME: rd_nxt = volume_r;
			`TEC_ADDR_HEAT_LO: rd_nxt = heat_out_r[31:0];
			`TEC_ADDR_HEAT_HI: rd_nxt = heat_out_r[63:32];
			`TEC_ADDR_COOL_LO: rd_nxt = cool_out_r[31:0];
			`TEC_ADDR_COOL_HI: rd_nxt = cool_out_r[63:32];
			`TEC_ADDR_INSUM_LO: rd_nxt = insum_out_r[31:0];
			`TEC_ADDR_INSUM_HI: rd_nxt = insum_out_r[63:32];
			`TEC_ADDR_OUTSUM_LO: rd_nxt = outsum_out_r[31:0];
			`TEC_ADDR_OUTSUM_HI: rd_nxt = outsum_out_r[63:32];
			default: begin
				rd_nxt = 32'h0000_0000;
				hit_nxt = 1'h0;
			end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'h0;
			pslverr <= 1'h0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~hit_nxt;
			if (psel && !penable && !pwrite)
				prdata <= rd_nxt;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `TEC_CTRL_RST;
			offset_r <= `TEC_OFFSET_RST;
			limit_r <= `TEC_LIMIT_RST;
		end else if (wr_en) begin
			case (paddr)
				`TEC_ADDR_CTRL: ctrl_r <= pwdata & `TEC_CTRL_MASK;
				`TEC_ADDR_OFFSET: begin
					if (offset_en) begin
						if ($signed(wr_off) > $signed(`TEC_OFFSET_MAX))
							offset_r <= `TEC_OFFSET_MAX;
						else if ($signed(wr_off) < $signed(`TEC_OFFSET_MIN))
							offset_r <= `TEC_OFFSET_MIN;
						else
							offset_r <= wr_off;
					end
				end
				`TEC_ADDR_LIMIT: limit_r <= pwdata[15:0];
				default: ;
			endcase
		end
	end
endmodule // tec_calc

// [hdl/tec_defs.vh]
`ifndef TEC_DEFS_VH
`define TEC_DEFS_VH

// Register byte offsets
`define TEC_ADDR_CTRL 8'h00
`define TEC_ADDR_OFFSET 8'h04
`define TEC_ADDR_LIMIT 8'h08
`define TEC_ADDR_STATUS 8'h0c
`define TEC_ADDR_VOLUME 8'h10
`define TEC_ADDR_HEAT_LO 8'h14
`define TEC_ADDR_HEAT_HI 8'h18
`define TEC_ADDR_COOL_LO 8'h1c
`define TEC_ADDR_COOL_HI 8'h20
`define TEC_ADDR_INSUM_LO 8'h24
`define TEC_ADDR_INSUM_HI 8'h28
`define TEC_ADDR_OUTSUM_LO 8'h2c
`define TEC_ADDR_OUTSUM_HI 8'h30

// Control register fields
`define TEC_CTRL_AT_OUTLET 0
`define TEC_CTRL_LIMIT_EN 1
`define TEC_CTRL_OFFSET_EN 2
`define TEC_CTRL_SIM_VOL 3
`define TEC_CTRL_UNIT_LSB 4
`define TEC_CTRL_RES_LSB 6
`define TEC_CTRL_MASK 32'h0000_00ff

// Status register fields
`define TEC_STAT_INLET 0
`define TEC_STAT_OUTLET 1
`define TEC_STAT_FLOW 2
`define TEC_STAT_ENERGY 3
`define TEC_STAT_INSUM 4
`define TEC_STAT_OUTSUM 5
`define TEC_STAT_OFFSET_OFF 6

// Reset values
`define TEC_CTRL_RST 32'h0000_0044
`define TEC_LIMIT_RST 16'h61a8
`define TEC_OFFSET_RST 8'h00

// Offset limits, hundredths of a kelvin
`define TEC_OFFSET_MAX 8'h63
`define TEC_OFFSET_MIN 8'h9d

// Energy units
`define TEC_UNIT_KWH 2'h0
`define TEC_UNIT_MWH 2'h1
`define TEC_UNIT_GJ 2'h2
`define TEC_UNIT_WH 2'h3

// Raw energy counts per Wh, and Wh per selected unit
`define TEC_RAW_PER_WH 64'h0000_0017_4876_e800
`define TEC_KWH_TO_WH 10'h3e8
`define TEC_WH_PER_KWH 64'h0000_0000_0000_03e8
`define TEC_WH_PER_MWH 64'h0000_0000_000f_4240
`define TEC_WH_PER_GJ 64'h0000_0000_0004_3d28

// Temperature-volume sum divisors per resolution code
`define TEC_SUM_DIV_R0 64'h0000_0000_0000_2710
`define TEC_SUM_DIV_R1 64'h0000_0000_0001_86a0
`define TEC_SUM_DIV_R2 64'h0000_0000_000f_4240
`define TEC_SUM_DIV_R3 64'h0000_0000_0098_9680

// Litres per volume count per resolution code
`define TEC_LITRES_R0 10'h001
`define TEC_LITRES_R1 10'h00a
`define TEC_LITRES_R2 10'h064
`define TEC_LITRES_R3 10'h3e8

`endif

// [hdl/tec_div.v]
`timescale 1ns/1ps
module tec_div #(
	parameter NW = 96,
	parameter DW = 64,
	parameter CW = 7
) (
	input wire clk,
	input wire rst_n,
	input wire start,
	input wire [NW-1:0] dividend,
	input wire [DW-1:0] divisor,
	output reg [NW-1:0] quotient,
	output reg done
);
	localparam [31:0] LAST_W = NW - 1;

	reg [DW-1:0] rem_r;
	reg [NW-1:0] quo_r;
	reg [DW-1:0] dvs_r;
	reg [CW-1:0] cnt_r;
	reg busy_r;

	wire [DW:0] trial = {rem_r, quo_r[NW-1]};
	wire fits = trial >= {1'h0, dvs_r};
	wire [DW:0] trial_sub = trial - {1'h0, dvs_r};

	// Restoring division, one quotient bit per clock
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rem_r <= {DW{1'h0}};
			quo_r <= {NW{1'h0}};
			dvs_r <= {DW{1'h0}};
			cnt_r <= {CW{1'h0}};
			busy_r <= 1'h0;
			done <= 1'h0;
			quotient <= {NW{1'h0}};
		end else if (start) begin
			rem_r <= {DW{1'h0}};
			quo_r <= dividend;
			dvs_r <= divisor;
			cnt_r <= LAST_W[CW-1:0];
			busy_r <= 1'h1;
			done <= 1'h0;
		end else if (busy_r) begin
			rem_r <= fits ? trial_sub[DW-1:0] : trial[DW-1:0];
			quo_r <= {quo_r[NW-2:0], fits};
			if (cnt_r == {CW{1'h0}}) begin
				busy_r <= 1'h0;
				done <= 1'h1;
				quotient <= {quo_r[NW-2:0], fits};
			end else begin
				cnt_r <= cnt_r - {{(CW-1){1'h0}}, 1'h1};
			end
		end else begin
			done <= 1'h0;
		end
	end
endmodule // tec_div

// [test/tec_calc_properties.sv]
`timescale 1ns/1ps
module tec_calc_chk (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire inlet_error,
	input wire outlet_error,
	input wire flow_error,
	input wire inlet_invalid,
	input wire outlet_invalid,
	input wire diff_invalid,
	input wire flow_invalid,
	input wire power_invalid,
	input wire energy_invalid,
	input wire inlet_sum_invalid,
	input wire outlet_sum_invalid
);
	logic oen_r;
	wire setup = psel && !penable;
	wire rd_off = setup && !pwrite && paddr == 8'h04;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// Mirror of the offset enable bit
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			oen_r <= 1'b1;
		else if (psel && penable && pready && pwrite && paddr == 8'h00)
			oen_r <= pwdata[2];
	end

	AST_READY_NEXT: assert property (setup |=> pready)
		else $error("pready missing after setup");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_UNMAPPED: assert property (setup && !pwrite && paddr == 8'h34 |=> pready && pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");
	AST_INLET_FLAG: assert property (inlet_error |=> inlet_invalid && diff_invalid && power_invalid && energy_invalid && inlet_sum_invalid)
		else $error("inlet error flags missing");
	AST_OUTLET_FLAG: assert property (outlet_error |=> outlet_invalid && diff_invalid && energy_invalid && outlet_sum_invalid)
		else $error("outlet error flags missing");
	AST_FLOW_FLAG: assert property (flow_error |=> flow_invalid && power_invalid && inlet_sum_invalid && outlet_sum_invalid)
		else $error("flow error flags missing");
	AST_INLET_SEP: assert property (!inlet_error && !flow_error |=> !inlet_invalid && !inlet_sum_invalid)
		else $error("inlet flags without cause");
	AST_CLEAN: assert property (!inlet_error && !outlet_error && !flow_error [*2] |=> !energy_invalid && !diff_invalid && !power_invalid)
		else $error("energy flags without error");
	AST_OFFSET_RANGE: assert property (rd_off |=> prdata[7:0] <= 8'h63 || prdata[7:0] >= 8'h9d)
		else $error("offset outside range");
	AST_OFFSET_OFF: assert property (rd_off && !oen_r |=> prdata == 32'h0000_0000)
		else $error("disabled offset reads nonzero");
endmodule // tec_calc_chk

bind tec_calc tec_calc_chk u_chk (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
	.inlet_error, .outlet_error, .flow_error, .inlet_invalid, .outlet_invalid, .diff_invalid,
	.flow_invalid, .power_invalid, .energy_invalid, .inlet_sum_invalid, .outlet_sum_invalid
);

// [test/tec_feed.sv]
`timescale 1ns/1ps
module tec_feed (
	input wire pclk,
	output logic [15:0] inlet_temperature,
	output logic [15:0] outlet_temperature,
	output logic inlet_error,
	output logic outlet_error,
	output logic flow_error,
	output logic vol_strobe,
	output logic sim_vol_strobe
);
	initial begin
		inlet_temperature = 16'h0000;
		outlet_temperature = 16'h0000;
		inlet_error = 1'b0;
		outlet_error = 1'b0;
		flow_error = 1'b0;
		vol_strobe = 1'b0;
		sim_vol_strobe = 1'b0;
	end

	task err(input [2:0] e);
		{inlet_error, outlet_error, flow_error} <= e;
	endtask

	// One pulse per count, idle cycle between
	task run(input int n, input [15:0] a, input [15:0] b, input s);
		inlet_temperature <= a;
		outlet_temperature <= b;
		repeat (n) begin
			@(posedge pclk);
			vol_strobe <= !s;
			sim_vol_strobe <= s;
			@(posedge pclk);
			vol_strobe <= 1'b0;
			sim_vol_strobe <= 1'b0;
		end
	endtask
endmodule // tec_feed

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] rdat;
	logic rerr;
	logic [31:0] ue [4] = '{32'h0000_0498, 32'h0000_0001, 32'h0000_0004, 32'h0011_f38c};
	int err_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	wire [31:0] prdata;
	wire pready;
	wire pslverr;
	wire [15:0] t_in;
	wire [15:0] t_out;
	wire e_in;
	wire e_out;
	wire e_fl;
	wire vs;
	wire svs;

	always #2 pclk = ~pclk;

	tec_calc u_tec_calc (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.inlet_temperature(t_in), .outlet_temperature(t_out), .inlet_error(e_in),
		.outlet_error(e_out), .flow_error(e_fl), .vol_strobe(vs), .sim_vol_strobe(svs),
		.inlet_invalid(), .outlet_invalid(), .diff_invalid(), .flow_invalid(), .power_invalid(),
		.energy_invalid(), .inlet_sum_invalid(), .outlet_sum_invalid()
	);

	tec_feed u_feed (
		.pclk(pclk), .inlet_temperature(t_in), .outlet_temperature(t_out), .inlet_error(e_in),
		.outlet_error(e_out), .flow_error(e_fl), .vol_strobe(vs), .sim_vol_strobe(svs)
	);

	task results;
		$display("Checks %0d errors %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			results;
		end
	end

	task chk(input string n, input [31:0] s, input [31:0] e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	task apb(input [7:0] a, input w, input [31:0] d);
		int i;
		i = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1);
		chk("wait states", i, 32'h0000_0001);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task wr(input [7:0] a, input [31:0] d);
		apb(a, 1'b1, d);
	endtask

	task rd(input [7:0] a, input [31:0] e);
		apb(a, 1'b0, 32'h0000_0000);
		chk($sformatf("reg %h", a), rdat, e);
	endtask

	// Readouts refresh round robin, so settle first
	task tot(input [15:0] h, input [15:0] c, input [15:0] i, input [15:0] o, input [15:0] v);
		repeat (500) @(posedge pclk);
		rd(8'h14, {16'h0000, h});
		rd(8'h1c, {16'h0000, c});
		rd(8'h24, {16'h0000, i});
		rd(8'h2c, {16'h0000, o});
		rd(8'h10, {16'h0000, v});
	endtask

	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(8'h00, 32'h0000_0044);
		rd(8'h08, 32'h0000_61a8);
		rd(8'h04, 32'h0000_0000);
		rd(8'h0c, 32'h0000_0000);
		apb(8'h34, 1'b0, 32'h0000_0000);
		chk("slverr", {31'h0, rerr}, 32'h0000_0001);
		chk("unmapped", rdat, 32'h0000_0000);
		wr(8'h10, 32'h0000_0005);
		rd(8'h10, 32'h0000_0000);
		wr(8'h00, 32'h0000_0074);
		u_feed.run(20, 16'h251c, 16'h1194, 1'b0);
		tot(16'h2cf1, 16'h0000, 16'h0013, 16'h0009, 16'h0014);
		wr(8'h00, 32'h0000_0075);
		u_feed.run(10, 16'h03e8, 16'h05dc, 1'b0);
		tot(16'h2cf1, 16'h0243, 16'h0014, 16'h000a, 16'h001e);
		u_feed.run(5, 16'h07d0, 16'h07d0, 1'b0);
		tot(16'h2cf1, 16'h0243, 16'h0015, 16'h000b, 16'h0023);
		u_feed.err(3'b100);
		u_feed.run(2, 16'h251c, 16'h1194, 1'b0);
		rd(8'h0c, 32'h0000_0019);
		tot(16'h2cf1, 16'h0243, 16'h0015, 16'h000c, 16'h0025);
		u_feed.err(3'b010);
		u_feed.run(2, 16'h251c, 16'h1194, 1'b0);
		rd(8'h0c, 32'h0000_002a);
		tot(16'h2cf1, 16'h0243, 16'h0016, 16'h000c, 16'h0027);
		u_feed.err(3'b001);
		u_feed.run(2, 16'h251c, 16'h1194, 1'b0);
		rd(8'h0c, 32'h0000_003c);
		tot(16'h2cf1, 16'h0243, 16'h0016, 16'h000c, 16'h0027);
		u_feed.err(3'b000);
		wr(8'h08, 32'h0000_1388);
		wr(8'h00, 32'h0000_0076);
		u_feed.run(1, 16'h0fa0, 16'h0bb8, 1'b0);
		u_feed.run(1, 16'h1388, 16'h0fa0, 1'b0);
		u_feed.run(1, 16'h0fa0, 16'h1388, 1'b0);
		u_feed.run(1, 16'h1388, 16'h1770, 1'b0);
		tot(16'h2d64, 16'h02b6, 16'h0018, 16'h000e, 16'h002b);
		wr(8'h04, 32'h0000_0064);
		apb(8'h04, 1'b0, 32'h0000_0000);
		chk("offset", {24'h0, rdat[7:0]}, 32'h0000_0063);
		wr(8'h04, 32'h0000_009c);
		apb(8'h04, 1'b0, 32'h0000_0000);
		chk("offset", {24'h0, rdat[7:0]}, 32'h0000_009d);
		wr(8'h04, 32'h0000_0032);
		wr(8'h00, 32'h0000_0074);
		u_feed.run(1, 16'h0b90, 16'h0b90, 1'b0);
		tot(16'h2d64, 16'h02b6, 16'h0019, 16'h000e, 16'h002c);
		wr(8'h00, 32'h0000_0070);
		wr(8'h04, 32'h0000_0010);
		rd(8'h04, 32'h0000_0000);
		rd(8'h0c, 32'h0000_0040);
		wr(8'h00, 32'h0000_0078);
		u_feed.run(2, 16'h251c, 16'h1194, 1'b0);
		u_feed.run(3, 16'h03e8, 16'h03e8, 1'b1);
		tot(16'h2d64, 16'h02b6, 16'h0019, 16'h000e, 16'h002f);
		wr(8'h00, 32'h0000_00f0);
		u_feed.run(6, 16'h4650, 16'h03e8, 1'b0);
		for (int u = 0; u < 4; u++) begin
			wr(8'h00, 32'h0000_00c0 | (u << 4));
			repeat (500) @(posedge pclk);
			rd(8'h14, ue[u]);
		end
		rd(8'h18, 32'h0000_0000);
		rd(8'h24, 32'h0000_000b);
		rd(8'h10, 32'h0000_0035);
		wr(8'h00, 32'h0000_0000);
		repeat (500) @(posedge pclk);
		rd(8'h24, 32'h0000_2b2d);
		wr(8'h00, 32'h0000_0080);
		repeat (500) @(posedge pclk);
		rd(8'h24, 32'h0000_006e);
		results;
	end
endmodule // testbench
